// file: shared/cecctl_pkg.sv
// constants, types and register map of the cec control block
// Contract
// - function runs only while module enable set
// - disabled module gates all clocks but enable's
// - disabling keeps every register setting
// - idle mode operation needs idle enable set
// - one write sets idle and module enable
// - address field is sixteen-bit own-address bitmap
// - broadcast received whatever the bitmap holds
// - broadcast acknowledged only when bit 15 set
// - software reset stops reception, drops data
// - software reset stops transmission, releases line
// - software reset clears registers except module enable; idle enable is kept too
// - software reset bit write-only, reads zero
// - receive enable write arms or stops receiver
// - receive enable reads actual receiver state
// - receiver follows enable after delay, readback shows it
package cecctl_pkg;
    localparam logic [7:0]  OFF_ENABLE = 8'h00;
    localparam logic [7:0]  OFF_ADDR   = 8'h04;
    localparam logic [7:0]  OFF_SWRST  = 8'h08;
    localparam logic [7:0]  OFF_RXEN   = 8'h0C;
    localparam logic [7:0]  OFF_RCR1   = 8'h14;
    localparam logic [7:0]  OFF_RCR2   = 8'h18;
    localparam logic [7:0]  OFF_RCR3   = 8'h1C;
    localparam int          BIT_MODEN  = 0;
    localparam int          BIT_IDLEEN = 1;
    localparam int          BIT_SWRST  = 0;
    localparam int          BIT_RXEN   = 0;
    localparam int          MAP_W      = 16;
    localparam logic [3:0]  BCAST_ADDR = 4'hF;
    localparam logic [15:0] RST_MAP    = 16'h0000;
    localparam logic [31:0] RST_RCR    = 32'h0000_0000;
    localparam logic        RST_BIT    = 1'b0;
    localparam logic [31:0] MASK_RCR1  = 32'h0137_777F;
    localparam logic [31:0] MASK_RCR2  = 32'hFFFF_FFFF;
    localparam logic [31:0] MASK_RCR3  = 32'hFFFF_FFFF;
    localparam int          CLK_HZ     = 10_000_000;
    localparam int          FS_HZ      = 32_768;
    localparam int          FS_DIV     = CLK_HZ / FS_HZ;
    localparam int          RX_TICKS   = 2;
    typedef enum logic [1:0] {
        DEC_IDLE  = 2'b00,
        DEC_OWN   = 2'b01,
        DEC_BCAST = 2'b10,
        DEC_SKIP  = 2'b11
    } cecctl_dec_t;
endpackage : cecctl_pkg

// file: rtl/cecctl_rx_gate.sv
// receiver run state that follows the requested enable on sample ticks
module cecctl_rx_gate #(
    parameter int TICKS = cecctl_pkg::RX_TICKS
) (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst,
    input  wire logic ce,
    // control
    input  wire logic tick,
    input  wire logic abort,
    input  wire logic request,
    // state
    output logic      active_r
);
    logic [TICKS-1:0] pipe_r;

    // request walks through sample ticks; abort empties it at once
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pipe_r <= '0;
        end else if (ce) begin
            if (abort) begin
                pipe_r <= '0;
            end else if (tick) begin
                pipe_r <= {pipe_r[TICKS-2:0], request};
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            active_r <= cecctl_pkg::RST_BIT;
        end else if (ce) begin
            if (abort) begin
                active_r <= 1'b0;
            end else if (tick) begin
                active_r <= pipe_r[TICKS-1];
            end
        end
    end
endmodule : cecctl_rx_gate

// file: rtl/cecctl_top.sv
// cec control registers: enable, idle, address map, software reset, receive enable
module cecctl_top #(
    parameter int FS_DIV = cecctl_pkg::FS_DIV
) (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    input  wire logic        ce,
    // apb slave
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // power manager
    input  wire logic        idleMode,
    // receiver and transmitter cores
    input  wire logic        destValid,
    input  wire logic [3:0]  destAddr,
    input  wire logic        txDriveLow,
    // control outputs
    output logic             cecClkEn_r,
    output logic             cecRun_r,
    output logic             sampleTick_r,
    output logic             rxActive_r,
    output logic             rxAbort_r,
    output logic             txAbort_r,
    output logic             lineDriveOe_r,
    output logic             acceptMsg_r,
    output logic             ackLow_r,
    output cecctl_pkg::cecctl_dec_t decKind_r,
    output logic [15:0]      addrMap_r,
    output logic [31:0]      rcrOne_r,
    output logic [31:0]      rcrTwo_r,
    output logic [31:0]      rcrThree_r
);
    logic        modEn_r;
    logic        idleEn_r;
    logic        rxReq_r;
    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic [15:0] tickCnt_r;
    logic        setup;
    logic        wrAcc;
    logic        mapped;
    logic        gatedWr;
    logic        swWrite;
    logic        running;
    logic [31:0] rdVal;

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    assign setup   = psel && !penable;
    assign wrAcc   = psel && penable && pready_r && pwrite;
    // writes other than to the enable word need the module clock
    assign gatedWr = wrAcc && modEn_r && !pslverr_r;
    assign swWrite = gatedWr && paddr == cecctl_pkg::OFF_SWRST && pwdata[cecctl_pkg::BIT_SWRST];
    assign running = modEn_r && (!idleMode || idleEn_r);

    always_comb begin
        case (paddr)
            cecctl_pkg::OFF_ENABLE,
            cecctl_pkg::OFF_ADDR,
            cecctl_pkg::OFF_SWRST,
            cecctl_pkg::OFF_RXEN,
            cecctl_pkg::OFF_RCR1,
            cecctl_pkg::OFF_RCR2,
            cecctl_pkg::OFF_RCR3: mapped = 1'b1;
            default:              mapped = 1'b0;
        endcase
    end

    always_comb begin
        rdVal = 32'h0000_0000;
        case (paddr)
            cecctl_pkg::OFF_ENABLE: begin
                rdVal[cecctl_pkg::BIT_MODEN]  = modEn_r;
                rdVal[cecctl_pkg::BIT_IDLEEN] = idleEn_r;
            end
            cecctl_pkg::OFF_ADDR:  rdVal[15:0] = addrMap_r;
            cecctl_pkg::OFF_SWRST: rdVal = 32'h0000_0000;
            cecctl_pkg::OFF_RXEN:  rdVal[cecctl_pkg::BIT_RXEN] = rxActive_r;
            cecctl_pkg::OFF_RCR1:  rdVal = rcrOne_r;
            cecctl_pkg::OFF_RCR2:  rdVal = rcrTwo_r;
            cecctl_pkg::OFF_RCR3:  rdVal = rcrThree_r;
            default:               rdVal = 32'h0000_0000;
        endcase
    end

    // no wait state: answer is prepared at the setup edge
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0000_0000;
        end else if (ce) begin
            pready_r  <= setup;
            pslverr_r <= setup && !mapped;
            prdata_r  <= (setup && !pwrite) ? rdVal : 32'h0000_0000;
        end
    end

    // enable word keeps its clock and survives software reset
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            modEn_r  <= cecctl_pkg::RST_BIT;
            idleEn_r <= cecctl_pkg::RST_BIT;
        end else if (ce && wrAcc && !pslverr_r && paddr == cecctl_pkg::OFF_ENABLE) begin
            modEn_r  <= pwdata[cecctl_pkg::BIT_MODEN];
            idleEn_r <= pwdata[cecctl_pkg::BIT_IDLEEN];
        end
    end

    // settings hold while disabled since their clock is stopped
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            addrMap_r <= cecctl_pkg::RST_MAP;
        end else if (ce) begin
            if (swWrite) begin
                addrMap_r <= cecctl_pkg::RST_MAP;
            end else if (gatedWr && paddr == cecctl_pkg::OFF_ADDR) begin
                addrMap_r <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rcrOne_r   <= cecctl_pkg::RST_RCR;
            rcrTwo_r   <= cecctl_pkg::RST_RCR;
            rcrThree_r <= cecctl_pkg::RST_RCR;
        end else if (ce) begin
            if (swWrite) begin
                rcrOne_r   <= cecctl_pkg::RST_RCR;
                rcrTwo_r   <= cecctl_pkg::RST_RCR;
                rcrThree_r <= cecctl_pkg::RST_RCR;
            end else if (gatedWr) begin
                if (paddr == cecctl_pkg::OFF_RCR1) begin
                    rcrOne_r <= pwdata & cecctl_pkg::MASK_RCR1;
                end
                if (paddr == cecctl_pkg::OFF_RCR2) begin
                    rcrTwo_r <= pwdata & cecctl_pkg::MASK_RCR2;
                end
                if (paddr == cecctl_pkg::OFF_RCR3) begin
                    rcrThree_r <= pwdata & cecctl_pkg::MASK_RCR3;
                end
            end
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rxReq_r <= cecctl_pkg::RST_BIT;
        end else if (ce) begin
            if (swWrite) begin
                rxReq_r <= cecctl_pkg::RST_BIT;
            end else if (gatedWr && paddr == cecctl_pkg::OFF_RXEN) begin
                rxReq_r <= pwdata[cecctl_pkg::BIT_RXEN];
            end
        end
    end

    // gated clock enable and run state for the cec logic
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cecClkEn_r <= 1'b0;
            cecRun_r   <= 1'b0;
        end else if (ce) begin
            cecClkEn_r <= modEn_r;
            cecRun_r   <= running;
        end
    end

    // sampling clock divider; stopped with the module to save power
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tickCnt_r    <= 16'h0000;
            sampleTick_r <= 1'b0;
        end else if (ce) begin
            if (!running || tickCnt_r == 16'(FS_DIV - 1)) begin
                tickCnt_r <= 16'h0000;
            end else begin
                tickCnt_r <= tickCnt_r + 16'h0001;
            end
            sampleTick_r <= running && tickCnt_r == 16'(FS_DIV - 1);
        end
    end

    cecctl_rx_gate u_rxGate (
        .clock    (clock),
        .rst      (rst),
        .ce       (ce && (modEn_r || swWrite)),
        .tick     (sampleTick_r),
        .abort    (swWrite),
        .request  (rxReq_r),
        .active_r (rxActive_r)
    );

    // software reset aborts both directions and frees the line
    // the core sees the abort a cycle late, so the line stays free meanwhile
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rxAbort_r     <= 1'b0;
            txAbort_r     <= 1'b0;
            lineDriveOe_r <= 1'b0;
        end else if (ce) begin
            rxAbort_r     <= swWrite;
            txAbort_r     <= swWrite;
            lineDriveOe_r <= txDriveLow && running && !swWrite && !txAbort_r;
        end
    end

    // destination decision: own bitmap match or broadcast
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            acceptMsg_r <= 1'b0;
            ackLow_r    <= 1'b0;
            decKind_r   <= cecctl_pkg::DEC_IDLE;
        end else if (ce) begin
            acceptMsg_r <= 1'b0;
            ackLow_r    <= 1'b0;
            decKind_r   <= cecctl_pkg::DEC_IDLE;
            if (destValid && running && rxActive_r && !swWrite) begin
                if (destAddr == cecctl_pkg::BCAST_ADDR) begin
                    acceptMsg_r <= 1'b1;
                    ackLow_r    <= addrMap_r[cecctl_pkg::BCAST_ADDR];
                    decKind_r   <= cecctl_pkg::DEC_BCAST;
                end else if (addrMap_r[destAddr]) begin
                    acceptMsg_r <= 1'b1;
                    ackLow_r    <= 1'b1;
                    decKind_r   <= cecctl_pkg::DEC_OWN;
                end else begin
                    decKind_r   <= cecctl_pkg::DEC_SKIP;
                end
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    logic bcastSeen;
    logic enWr;
    assign bcastSeen = ce && destValid && running && rxActive_r && !swWrite
                       && destAddr == cecctl_pkg::BCAST_ADDR;
    assign enWr      = ce && wrAcc && !pslverr_r && paddr == cecctl_pkg::OFF_ENABLE;

    property p_modOff;
        ce && !modEn_r |=> !cecRun_r && !sampleTick_r;
    endproperty
    a_modOff: assert property (p_modOff) else $error("cec runs while disabled");

    property p_clkGate;
        ce |=> cecClkEn_r == $past(modEn_r);
    endproperty
    a_clkGate: assert property (p_clkGate) else $error("clock enable not following module enable");

    property p_keepSettings;
        ce && !modEn_r && !enWr |=> addrMap_r == $past(addrMap_r) && rcrOne_r == $past(rcrOne_r);
    endproperty
    a_keepSettings: assert property (p_keepSettings) else $error("setting changed while disabled");

    property p_idleStop;
        ce && modEn_r && idleMode && !idleEn_r |=> !cecRun_r;
    endproperty
    a_idleStop: assert property (p_idleStop) else $error("cec runs in idle without idle enable");

    property p_bothEn;
        enWr && pwdata[1:0] == 2'b11 |=> modEn_r && idleEn_r;
    endproperty
    a_bothEn: assert property (p_bothEn) else $error("single write did not set both enables");

    property p_bcastRx;
        bcastSeen |=> acceptMsg_r && decKind_r == cecctl_pkg::DEC_BCAST;
    endproperty
    a_bcastRx: assert property (p_bcastRx) else $error("broadcast not accepted");

    property p_bcastAck;
        bcastSeen |=> ackLow_r == $past(addrMap_r[15]);
    endproperty
    a_bcastAck: assert property (p_bcastAck) else $error("broadcast ack wrong");

    property p_swRx;
        ce && swWrite |=> !rxActive_r && rxAbort_r && !acceptMsg_r;
    endproperty
    a_swRx: assert property (p_swRx) else $error("reception not stopped by software reset");

    property p_swTx;
        ce && swWrite |=> txAbort_r && !lineDriveOe_r;
    endproperty
    a_swTx: assert property (p_swTx) else $error("line still driven after software reset");

    property p_swRegs;
        ce && swWrite |=> addrMap_r == 16'h0000 && rcrOne_r == 32'h0000_0000 && modEn_r == $past(modEn_r);
    endproperty
    a_swRegs: assert property (p_swRegs) else $error("software reset register effect wrong");

    property p_swRead;
        ce && setup && !pwrite && paddr == cecctl_pkg::OFF_SWRST |=> prdata_r == 32'h0000_0000;
    endproperty
    a_swRead: assert property (p_swRead) else $error("software reset reads nonzero");

    property p_rxFollow;
        ce && $rose(rxActive_r) |-> $past(rxReq_r);
    endproperty
    a_rxFollow: assert property (p_rxFollow) else $error("receiver started without request");

    property p_rxRead;
        ce && setup && !pwrite && paddr == cecctl_pkg::OFF_RXEN |=> prdata_r == {31'h0, $past(rxActive_r)};
    endproperty
    a_rxRead: assert property (p_rxRead) else $error("receive enable readback wrong");

    property p_upperZero;
        ce && setup && !pwrite && paddr == cecctl_pkg::OFF_ADDR |=> prdata_r[31:16] == 16'h0000;
    endproperty
    a_upperZero: assert property (p_upperZero) else $error("upper address bits nonzero");

    property p_errRead;
        ce && setup && !mapped |=> pslverr_r && prdata_r == 32'h0000_0000;
    endproperty
    a_errRead: assert property (p_errRead) else $error("unmapped access not refused");

    property p_errWrite;
        ce && wrAcc && pslverr_r |=> modEn_r == $past(modEn_r) && addrMap_r == $past(addrMap_r);
    endproperty
    a_errWrite: assert property (p_errWrite) else $error("unmapped write changed a register");

    property p_rxHold;
        ce && !modEn_r |=> $stable(rxActive_r);
    endproperty
    a_rxHold: assert property (p_rxHold) else $error("receiver state changed while disabled");

    property p_lineFree;
        ce && txAbort_r |=> !lineDriveOe_r;
    endproperty
    a_lineFree: assert property (p_lineFree) else $error("line driven while transmit abort pending");

    c_bcast:  cover property (bcastSeen ##1 ackLow_r);
    c_own:    cover property (ce && decKind_r == cecctl_pkg::DEC_OWN);
    c_swRst:  cover property (ce && swWrite ##1 rxAbort_r);
    c_rxOn:   cover property (ce && $rose(rxActive_r));
endmodule : cecctl_top

// file: verif/cecctl_line_model.sv
// far side model: receiver and transmitter cores facing the shared line
module cecctl_line_model (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // bench commands
    input  wire logic       req,
    input  wire logic [3:0] reqAddr,
    input  wire logic       drive,
    // from the control block
    input  wire logic       txAbort,
    // toward the control block
    output logic            destValid,
    output logic [3:0]      destAddr,
    output logic            txDriveLow
);
    timeunit 1ns;
    timeprecision 1ns;
    logic held;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            destValid <= 1'b0;
            destAddr  <= 4'h0;
        end else if (req) begin
            destValid <= 1'b1;
            destAddr  <= reqAddr;
        end else begin
            destValid <= 1'b0;
            // address is stale outside the pulse, so show a moving value
            destAddr  <= ~destAddr;
        end
    end
    // a transmitter stopped by an abort stays released until asked again
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            held       <= 1'b0;
            txDriveLow <= 1'b0;
        end else begin
            held       <= txAbort | (held & drive);
            txDriveLow <= drive & ~txAbort & ~held;
        end
    end
endmodule : cecctl_line_model

// file: verif/test_cecctl_top.sv
// self-checking bench of the cec control block
module test_cecctl_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clock, rst, ce, psel, penable, pwrite, pready, pslverr, idleMode;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd, addrMapAll;
    logic        err, req, drive, destValid, txDriveLow, sawAbort;
    logic [3:0]  reqAddr, destAddr;
    logic        cecClkEn_r, cecRun_r, sampleTick_r, rxActive_r, rxAbort_r, txAbort_r;
    logic        lineDriveOe_r, acceptMsg_r, ackLow_r;
    cecctl_pkg::cecctl_dec_t decKind_r;
    logic [15:0] addrMap_r;
    logic [31:0] rcrOne_r, rcrTwo_r, rcrThree_r;
    int          failures, compares, n, polls, ticks;
    cecctl_top #(.FS_DIV(4)) cecctl_top_i (
        .clock(clock), .rst(rst), .ce(ce), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .idleMode(idleMode), .destValid(destValid), .destAddr(destAddr), .txDriveLow(txDriveLow),
        .cecClkEn_r(cecClkEn_r), .cecRun_r(cecRun_r), .sampleTick_r(sampleTick_r),
        .rxActive_r(rxActive_r), .rxAbort_r(rxAbort_r), .txAbort_r(txAbort_r),
        .lineDriveOe_r(lineDriveOe_r), .acceptMsg_r(acceptMsg_r), .ackLow_r(ackLow_r),
        .decKind_r(decKind_r), .addrMap_r(addrMap_r), .rcrOne_r(rcrOne_r),
        .rcrTwo_r(rcrTwo_r), .rcrThree_r(rcrThree_r));
    cecctl_line_model cecctl_line_model_i (
        .clock(clock), .rst(rst), .req(req), .reqAddr(reqAddr), .drive(drive),
        .txAbort(txAbort_r), .destValid(destValid), .destAddr(destAddr), .txDriveLow(txDriveLow));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) if (rxAbort_r === 1'b1 && txAbort_r === 1'b1) sawAbort <= 1'b1;
    task conclude;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : conclude
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one apb transfer; the master holds everything until pready is sampled high
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            failures++;
            conclude();
        end
    endtask : apb
    task rdChk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask : rdChk
    // one destination pulse from the far side, then the decision a cycle later
    task probe(input logic [3:0] a, input logic [3:0] exp);
        @(posedge clock);
        req     <= 1'b1;
        reqAddr <= a;
        @(posedge clock);
        req <= 1'b0;
        @(posedge clock);
        #1;
        check({28'h000_0000, acceptMsg_r, ackLow_r, 2'(decKind_r)}, {28'h000_0000, exp});
    endtask : probe
    initial begin
        rst = 1'b1; ce = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0000_0000; idleMode = 1'b0; req = 1'b0; reqAddr = 4'h0; drive = 1'b0;
        sawAbort = 1'b0; failures = 0; compares = 0; addrMapAll = 32'hFFFF_8005;
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        rdChk(cecctl_pkg::OFF_ENABLE, 32'h0000_0000);
        rdChk(cecctl_pkg::OFF_ADDR, 32'h0000_0000);
        rdChk(cecctl_pkg::OFF_RXEN, 32'h0000_0000);
        rdChk(8'h10, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001);
        apb(1'b1, cecctl_pkg::OFF_ADDR, 32'h0000_0005);
        rdChk(cecctl_pkg::OFF_ADDR, 32'h0000_0000);
        check({31'h0, cecClkEn_r}, 32'h0000_0000);
        apb(1'b1, cecctl_pkg::OFF_ENABLE, 32'hFFFF_FFFD);
        rdChk(cecctl_pkg::OFF_ENABLE, 32'h0000_0001);
        check({30'h0, cecClkEn_r, cecRun_r}, 32'h0000_0003);
        ticks = 0;
        repeat (8) begin
            @(posedge clock);
            ticks += sampleTick_r;
        end
        check(ticks, 32'h0000_0002);
        // clock enable low freezes the run state even though idle starts
        ce       <= 1'b0;
        idleMode <= 1'b1;
        repeat (3) @(posedge clock);
        check({31'h0, cecRun_r}, 32'h0000_0001);
        ce       <= 1'b1;
        repeat (3) @(posedge clock);
        check({31'h0, cecRun_r}, 32'h0000_0000);
        apb(1'b1, cecctl_pkg::OFF_ENABLE, 32'h0000_0003);
        rdChk(cecctl_pkg::OFF_ENABLE, 32'h0000_0003);
        check({31'h0, cecRun_r}, 32'h0000_0001);
        idleMode <= 1'b0;
        // receive controls go in before the receiver is armed
        apb(1'b1, cecctl_pkg::OFF_RCR1, 32'hFFFF_FFFF);
        apb(1'b1, cecctl_pkg::OFF_RCR2, 32'hA5A5_5A5A);
        apb(1'b1, cecctl_pkg::OFF_RCR3, 32'h1234_5678);
        rdChk(cecctl_pkg::OFF_RCR1, cecctl_pkg::MASK_RCR1);
        rdChk(cecctl_pkg::OFF_RCR3, 32'h1234_5678);
        check(rcrTwo_r, 32'hA5A5_5A5A);
        check(rcrThree_r, 32'h1234_5678);
        apb(1'b1, cecctl_pkg::OFF_ADDR, addrMapAll);
        rdChk(cecctl_pkg::OFF_ADDR, 32'h0000_8005);
        check({16'h0000, addrMap_r}, 32'h0000_8005);
        apb(1'b1, cecctl_pkg::OFF_RXEN, 32'hFFFF_FFFF);
        rdChk(cecctl_pkg::OFF_RXEN, 32'h0000_0000);
        polls = 0;
        do begin
            apb(1'b0, cecctl_pkg::OFF_RXEN, 32'h0000_0000);
            polls++;
        end while (rd !== 32'h0000_0001 && polls < 40);
        check(rd, 32'h0000_0001);
        if (rd !== 32'h0000_0001) conclude();
        probe(4'h2, 4'b1101);
        probe(4'h0, 4'b1101);
        probe(4'h1, 4'b0011);
        probe(4'hF, 4'b1110);
        apb(1'b1, cecctl_pkg::OFF_ADDR, 32'h0000_0005);
        probe(4'hF, 4'b1010);
        // receiver is armed here, so only the disable can refuse the message
        apb(1'b1, cecctl_pkg::OFF_ENABLE, 32'h0000_0000);
        probe(4'hF, 4'b0000);
        apb(1'b1, cecctl_pkg::OFF_ENABLE, 32'h0000_0003);
        drive <= 1'b1;
        repeat (4) @(posedge clock);
        check({31'h0, lineDriveOe_r}, 32'h0000_0001);
        apb(1'b1, cecctl_pkg::OFF_SWRST, 32'h0000_0001);
        repeat (3) @(posedge clock);
        check({31'h0, sawAbort}, 32'h0000_0001);
        check({30'h0, lineDriveOe_r, rxActive_r}, 32'h0000_0000);
        drive <= 1'b0;
        rdChk(cecctl_pkg::OFF_SWRST, 32'h0000_0000);
        rdChk(cecctl_pkg::OFF_ADDR, 32'h0000_0000);
        rdChk(cecctl_pkg::OFF_RCR2, 32'h0000_0000);
        rdChk(cecctl_pkg::OFF_RXEN, 32'h0000_0000);
        rdChk(cecctl_pkg::OFF_ENABLE, 32'h0000_0003);
        probe(4'hF, 4'b0000);
        // settings survive a disable and re-enable
        apb(1'b1, cecctl_pkg::OFF_ADDR, 32'h0000_0005);
        apb(1'b1, cecctl_pkg::OFF_ENABLE, 32'h0000_0000);
        repeat (3) @(posedge clock);
        check({30'h0, cecClkEn_r, cecRun_r}, 32'h0000_0000);
        probe(4'hF, 4'b0000);
        apb(1'b1, cecctl_pkg::OFF_ENABLE, 32'h0000_0001);
        rdChk(cecctl_pkg::OFF_ADDR, 32'h0000_0005);
        apb(1'b1, 8'h24, 32'hFFFF_FFFF);
        check({31'h0, err}, 32'h0000_0001);
        rdChk(cecctl_pkg::OFF_ENABLE, 32'h0000_0001);
        conclude();
    end
endmodule : test_cecctl_top
